// ===== core/tafs_core.v
// Purpose: serial framing of a touch ADC, overlapped 15-clock schedule
// Assumes: host drives chip select, conversion clock and serial input;
//          conversion_clock is far slower than sys_clk (oversampled)
// Notes:   adc_code stands in for the analog converter core
//
// Operation
// - The next control byte may be shifted in while the current result shifts out.
// - Each 12-bit period spends 3 clocks acquiring and 12 clocks converting.
// - A 1 in the mode bit of the control byte selects 8-bit conversions.
// - An 8-bit conversion finishes four conversion clocks sooner than a 12-bit one.
// - In 8-bit mode both 12-clock transfers and overlapped 8-clock bursts work.
// - The host serial clock is the conversion clock and times every bit.
// - Chip select falling starts a transfer and enables busy and serial out.
// - The first eight clocks load the control byte, register updated bit by bit.
// - Busy rises at sampling and falls on the next conversion clock falling edge.
`timescale 1ns/100ps
`include "tafs_defines.vh"

module tafs_core #(
   parameter CODE_W = 12,
   parameter DEPTH  = `TAFS_FIFO_DEPTH
) (
   // clock and reset
   input  wire              sys_clk,
   input  wire              resetn,
   // serial pins from the host
   input  wire              cs_n,
   input  wire              conversion_clock,
   input  wire              serial_in,
   // serial pins toward the host
   output reg               serial_out_q,
   output reg               serial_oe_q,
   output reg               busy_q,
   output reg               busy_oe_q,
   // converter core
   input  wire [CODE_W-1:0] adc_code,
   output reg  [7:0]        ctrl_q,
   output reg               acquire_q,
   output reg               convert_q,
   output reg               overrun_q
);

   // conversion length for the selected resolution
   function [3:0] conv_len;
      input mode_8;
      begin
         conv_len = mode_8 ? `TAFS_CONV_8 : `TAFS_CONV_12;
      end
   endfunction

   reg  [2:0]        cs_sync_q;
   reg  [2:0]        clk_sync_q;
   reg  [1:0]        din_sync_q;
   reg  [3:0]        rx_cnt_q;
   reg  [3:0]        acq_cnt_q;
   reg  [CODE_W-1:0] shift_q;
   reg  [3:0]        bits_left_q;
   reg               pend_q;
   wire              cs_act;
   wire              cs_fall;
   wire              clk_rise;
   wire              clk_fall;
   wire              din;
   wire              launch;
   wire              fifo_in_ready;
   wire              fifo_out_valid;
   wire              fifo_pop;
   wire [CODE_W:0]   fifo_out_data;
   wire              shifter_idle;
   wire [3:0]        next_len;

   // pin synchronisers, first stage read only by the second
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cs_sync_q  <= 3'h7;
         clk_sync_q <= 3'h0;
         din_sync_q <= 2'h0;
      end else begin
         cs_sync_q  <= {cs_sync_q[1:0], cs_n};
         clk_sync_q <= {clk_sync_q[1:0], conversion_clock};
         din_sync_q <= {din_sync_q[0], serial_in};
      end
   end

   assign clk_rise = clk_sync_q[1] & ~clk_sync_q[2];
   assign clk_fall = ~clk_sync_q[1] & clk_sync_q[2];
   assign cs_act   = ~cs_sync_q[1];
   assign cs_fall  = ~cs_sync_q[1] & cs_sync_q[2];
   assign din      = din_sync_q[1];

   // control byte completes on the eighth rising edge
   assign launch = cs_act & clk_rise & (rx_cnt_q == `TAFS_CTRL_LEN - 4'h1);

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         serial_oe_q <= 1'b0;
         busy_oe_q   <= 1'b0;
      end else begin
         serial_oe_q <= cs_act;
         busy_oe_q   <= cs_act;
      end
   end

   // control byte receiver, bit by bit update
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rx_cnt_q  <= 4'h0;
         ctrl_q    <= `TAFS_CTRL_RESET;
         overrun_q <= 1'b0;
      end else if (!cs_act) begin
         rx_cnt_q <= 4'h0;
      end else begin
         if (cs_fall) begin
            overrun_q <= 1'b0;
         end
         if (clk_rise) begin
            if (rx_cnt_q == 4'h0) begin
               // start bit honoured even while a result shifts out
               if (din) begin
                  ctrl_q[`TAFS_CTRL_START] <= 1'b1;
                  rx_cnt_q                 <= 4'h1;
               end
            end else begin
               ctrl_q[3'h7 - rx_cnt_q[2:0]] <= din;
               if (launch) begin
                  rx_cnt_q <= 4'h0;
                  // sample dropped when the buffer cannot take it
                  if (!fifo_in_ready) begin
                     overrun_q <= 1'b1;
                  end
               end else begin
                  rx_cnt_q <= rx_cnt_q + 4'h1;
               end
            end
         end
      end
   end

   // acquisition window of three clocks before sampling
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         acquire_q <= 1'b0;
         acq_cnt_q <= 4'h0;
      end else if (!cs_act) begin
         acquire_q <= 1'b0;
         acq_cnt_q <= 4'h0;
      end else if (clk_rise) begin
         if (rx_cnt_q == `TAFS_ACQ_OPEN) begin
            acquire_q <= 1'b1;
            acq_cnt_q <= 4'h0;
         end else if (acquire_q) begin
            acq_cnt_q <= acq_cnt_q + 4'h1;
            // window closes on its third clock, the edge that samples
            if (acq_cnt_q == `TAFS_ACQ_CYCLES - 4'h1) begin
               acquire_q <= 1'b0;
            end
         end
      end
   end

   // busy from sampling
   // raised at the sampling edge even when the word waits in the buffer
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
      end else if (!cs_act) begin
         busy_q <= 1'b0;
      end else if (launch) begin
         busy_q <= 1'b1;
      end else if (clk_fall) begin
         busy_q <= 1'b0; // next falling edge ends it
      end
   end

   // sampled word carries its resolution bit; mode uses the bit just landing
   // on the eighth edge only for the power bits, so ctrl_q mode is final here
   tafs_fifo #(
      .WIDTH (CODE_W + 1),
      .DEPTH (DEPTH),
      .AW    (2)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (launch),
      .in_ready  (fifo_in_ready),
      .in_data   ({ctrl_q[`TAFS_CTRL_MODE], adc_code}),
      .out_valid (fifo_out_valid),
      .out_ready (shifter_idle),
      .out_data  (fifo_out_data)
   );

   // deselect drains the buffer so no stale result leaks into the next transfer
   assign shifter_idle = ~cs_act | (~pend_q & (bits_left_q == 4'h0));
   assign fifo_pop     = fifo_out_valid & shifter_idle;
   // resolution taken from the mode bit
   assign next_len     = conv_len(fifo_out_data[CODE_W]);

   // conversion and result shifter
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shift_q      <= {CODE_W{1'b0}};
         bits_left_q  <= 4'h0;
         pend_q       <= 1'b0;
         convert_q    <= 1'b0;
         serial_out_q <= 1'b0;
      end else if (!cs_act) begin
         bits_left_q  <= 4'h0;
         pend_q       <= 1'b0;
         convert_q    <= 1'b0;
         serial_out_q <= 1'b0;
      end else if (fifo_pop) begin
         // conversion starts on the buffered word
         pend_q      <= 1'b1;
         convert_q   <= 1'b1;
         bits_left_q <= next_len;
         // 8-bit codes are left aligned in the shifter
         shift_q     <= fifo_out_data[CODE_W] ?
                        {fifo_out_data[CODE_W-1:CODE_W-8], {(CODE_W-8){1'b0}}} :
                        fifo_out_data[CODE_W-1:0];
      end else if (clk_fall) begin
         pend_q <= 1'b0;
         if (bits_left_q != 4'h0) begin
            serial_out_q <= shift_q[CODE_W-1];
            shift_q      <= {shift_q[CODE_W-2:0], 1'b0};
            bits_left_q  <= bits_left_q - 4'h1;
            // shorter count ends 8-bit conversions early
            if (bits_left_q == 4'h1) begin
               convert_q <= 1'b0;
            end
         end else begin
            // trailing zeros fill any longer framing
            serial_out_q <= 1'b0;
         end
      end
   end

endmodule

// ===== core/tafs_defines.vh
// Purpose: shared constants for the touch ADC fast serial framing block
// Assumes: control byte arrives MSB first, start bit leading
// Notes:   bit positions index the 8-bit control register
`ifndef TAFS_DEFINES_VH
`define TAFS_DEFINES_VH

// control byte layout
`define TAFS_CTRL_LEN      4'h8
`define TAFS_CTRL_START    7
`define TAFS_CTRL_CH_HI    6
`define TAFS_CTRL_CH_LO    4
`define TAFS_CTRL_MODE     3
`define TAFS_CTRL_SERDFR   2
`define TAFS_CTRL_PD_HI    1
`define TAFS_CTRL_PD_LO    0
`define TAFS_CTRL_RESET    8'h00

// receive count at which acquisition opens (mode bit about to land)
`define TAFS_ACQ_OPEN      4'h4
// acquisition length in conversion clocks
`define TAFS_ACQ_CYCLES    4'h3

// conversion lengths in conversion clocks
`define TAFS_CONV_12       4'hC
`define TAFS_CONV_8        4'h8

// sample buffer depth
`define TAFS_FIFO_DEPTH    4

`endif

// ===== core/tafs_fifo.v
// Purpose: small sample buffer between the sampling point and the shifter
// Assumes: single clock, push and pop in the same cycle allowed
// Notes:   flip-flop storage addressed by index, honest full and empty
`timescale 1ns/100ps

module tafs_fifo #(
   parameter WIDTH = 13,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   // clock and reset
   input  wire             sys_clk,
   input  wire             resetn,
   // filling side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // draining side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   // handshake terms
   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage write
   always @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // pointers and fill count
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

endmodule

// ===== verification/tafs_monitor.sv
// Purpose: pin timing checker for tafs_core
// Assumes: conversion_clock levels last 5 sys_clk
// Notes:   raw clock edges lead the synced logic
`timescale 1ns/100ps
module tafs_monitor (
   // clock and reset
   input wire       sys_clk,
   input wire       resetn,
   // host pins
   input wire       cs_n,
   input wire       conversion_clock,
   // device outputs
   input wire       serial_out_q,
   input wire       serial_oe_q,
   input wire       busy_q,
   input wire       busy_oe_q,
   input wire [7:0] ctrl_q,
   input wire       acquire_q,
   input wire       convert_q,
   input wire       overrun_q
);
   reg       clk_q;
   reg [3:0] acq_n_q;
   reg [3:0] conv_n_q;
   wire      rise = conversion_clock & ~clk_q;
   wire      fall = ~conversion_clock & clk_q;
   // count raw rises while acquiring and raw falls (bits shifted) while converting
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         clk_q <= 1'b0;
         acq_n_q <= 4'h0;
         conv_n_q <= 4'h0;
      end else begin
         clk_q <= conversion_clock;
         acq_n_q <= acquire_q ? acq_n_q + {3'h0, rise} : 4'h0;
         conv_n_q <= convert_q ? conv_n_q + {3'h0, fall} : 4'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   AST_OE_OFF: assert property (cs_n [*5] |-> !serial_oe_q && !busy_oe_q)
      else $error("pins driven while deselected");
   AST_OE_ON: assert property (!cs_n [*5] |-> serial_oe_q && busy_oe_q)
      else $error("pins not driven while selected");
   AST_BUSY_END: assert property ($fell(busy_q)
      |-> !conversion_clock && !$past(conversion_clock))
      else $error("busy fell away from a falling edge");
   AST_BUSY_CONV: assert property ($rose(busy_q) |-> $fell(acquire_q))
      else $error("busy rose outside sampling");
   AST_BUSY_LEN: assert property ($rose(busy_q) |-> ##[1:8] !busy_q)
      else $error("busy held too long");
   AST_ACQ: assert property ($fell(acquire_q) |-> acq_n_q == 4'h3)
      else $error("acquisition length wrong");
   AST_CONV: assert property ($fell(convert_q) && !cs_n
      |-> conv_n_q == (ctrl_q[3] ? 4'h8 : 4'hC))
      else $error("conversion length wrong");
   AST_CTRL: assert property ($changed(ctrl_q) && ctrl_q != 8'h00
      |-> conversion_clock && !cs_n)
      else $error("control changed off a rising edge");
   AST_SDO: assert property ($changed(serial_out_q) && serial_oe_q |-> !conversion_clock)
      else $error("result bit changed off a falling edge");
   // main scenarios reached
   cover property ($rose(overrun_q));
   cover property ($fell(convert_q) && ctrl_q[3]);
   cover property ($fell(convert_q) && !ctrl_q[3]);
endmodule
bind tafs_core tafs_monitor i_tafs_monitor (.sys_clk, .resetn, .cs_n, .conversion_clock,
   .serial_out_q, .serial_oe_q, .busy_q, .busy_oe_q, .ctrl_q, .acquire_q, .convert_q,
   .overrun_q);

// ===== verification/tafs_host.sv
// Purpose: host serial master model
// Assumes: moves only at sys_clk falling edges
// Notes:   clock stands low between bursts
`timescale 1ns/100ps
module tafs_host (
   // system clock and device output
   input  wire  sys_clk,
   input  wire  sdo,
   // pins toward the device
   output logic cs_n = 1'b1,
   output logic cclk = 1'b0,
   output logic sdi  = 1'b0
);
   logic [127:0] rx;
   // shift n bits out and in, pausing after each byte when gap is set
   task run(input logic [127:0] tx, input int n, input bit gap);
      cs_n = 1'b0;
      rx = '0;
      repeat (4) @(negedge sys_clk);
      for (int j = 0; j < n; j++) begin
         sdi = tx[127-j];
         repeat (5) @(negedge sys_clk);
         rx = {rx[126:0], sdo};
         cclk = 1'b1;
         repeat (5) @(negedge sys_clk);
         cclk = 1'b0;
         if (gap && j % 8 == 7) repeat (9) @(negedge sys_clk);
      end
      repeat (5) @(negedge sys_clk);
      cs_n = 1'b1;
      sdi = ~sdi;
      repeat (6) @(negedge sys_clk);
   endtask
endmodule

// ===== verification/tafs_core_tb.sv
// Purpose: self-checking bench for tafs_core
// Assumes: host model drives the serial pins
// Notes:   results are read from the host capture
`timescale 1ns/100ps
module tafs_core_tb;
   localparam logic [11:0] CODE = 12'hA5C;
   logic       sys_clk;
   logic       resetn;
   logic [11:0] adc_code;
   wire        cs_n, cclk, sdi, sdo, soe, busy, boe, acq, conv, ovr;
   wire [7:0]  ctrl;
   int         miscompares = 0;
   int         comparisons = 0;
   tafs_core i_tafs_core (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n),
      .conversion_clock(cclk), .serial_in(sdi), .serial_out_q(sdo), .serial_oe_q(soe),
      .busy_q(busy), .busy_oe_q(boe), .adc_code(adc_code), .ctrl_q(ctrl),
      .acquire_q(acq), .convert_q(conv), .overrun_q(ovr));
   tafs_host host (.sys_clk(sys_clk), .sdo(sdo), .cs_n(cs_n), .cclk(cclk), .sdi(sdi));
   task cmp_word(input logic [11:0] got, input logic [11:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t word %h exp %h", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t flag %b exp %b", $time, got, exp);
      end
   endtask
   // one 24-clock frame at 12 bits
   task t_single;
      host.run({8'h93, 120'h0}, 24, 1'b0);
      cmp_word({4'h0, ctrl}, 12'h093);
      cmp_word(host.rx[15 -: 12], CODE);
      cmp_word({8'h0, host.rx[3:0]}, 12'h000);
      cmp_bit(ovr, 1'b0);
   endtask
   // two overlapped conversions 15 clocks apart, code changed between
   task t_overlap;
      fork
         host.run({8'h93, 7'h0, 8'h93, 105'h0}, 39, 1'b0);
         begin
            repeat (130) @(negedge sys_clk);
            adc_code = 12'h3C6;
         end
      join
      cmp_word(host.rx[30 -: 12], CODE);
      cmp_word(host.rx[15 -: 12], 12'h3C6);
      adc_code = CODE;
   endtask
   // two 8-bit conversions: 12 clocks apart, or in three 8-clock bursts
   task t_mode8(input bit gap);
      if (gap) begin
         host.run({8'h9B, 8'h9B, 112'h0}, 24, 1'b1);
         cmp_word({4'h0, host.rx[15 -: 8]}, {4'h0, CODE[11:4]});
         cmp_word({4'h0, host.rx[7 -: 8]}, {4'h0, CODE[11:4]});
      end else begin
         host.run({8'h9B, 4'h0, 8'h9B, 108'h0}, 32, 1'b0);
         cmp_word({4'h0, host.rx[23 -: 8]}, {4'h0, CODE[11:4]});
         cmp_word({8'h0, host.rx[15:12]}, 12'h000);
         cmp_word({4'h0, host.rx[11 -: 8]}, {4'h0, CODE[11:4]});
      end
      cmp_word({4'h0, ctrl}, 12'h09B);
   endtask
   // back-to-back bytes overfill the sample buffer
   task t_overrun;
      fork
         host.run({16{8'h93}}, 128, 1'b0);
         begin
            repeat (1270) @(negedge sys_clk);
            cmp_bit(ovr, 1'b1);
            cmp_bit(soe, 1'b1);
            cmp_bit(boe, 1'b1);
         end
      join
      cmp_word(host.rx[119 -: 12], CODE);
      cmp_bit(soe, 1'b0);
   endtask
   // free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // reset, then the scenarios
   initial begin
      resetn = 1'b0;
      adc_code = CODE;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) resetn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_single;
      t_overlap;
      t_mode8(1'b0);
      t_mode8(1'b1);
      t_overrun;
      t_single;
      close_out;
   end
   // watchdog against a hang
   initial begin
      #200000;
      miscompares++;
      close_out;
   end
   task close_out;
      if (miscompares == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
endmodule
